/* mcu_reset_sequencer.sv */
`timescale 1ns/1ps
`include "rstseq_regs.svh"
// What this block does
// - Merge five reset sources, record the cause.
// - Power-up: address zero, ports all inputs.
// - Pin release adds reset hold delay.
// - Key 00000 GPIO, 10101 reset, else reset.
// - Key reset restarts program counter at zero.
// - Low-voltage reset only after qualification time.
// - Low-voltage reset disabled in power-down.
// - Watchdog run reset like pin, sets timeout.
// - Watchdog sleep clears PC, SP, sets timeout.
// - Sleep wake start-up timer is sixteen cycles.
// - Flags follow reset cause table.
// - Power-on clears watchdog, counting starts.
// - Power-on stops timer, clears prescaler.
// - Power-on disables all interrupts.
// - Power-on puts stack pointer at top.
// - After reset, except watchdog sleep, ports set as inputs.
// - Bad watchdog key resets after 1-2 slow cycles.
module mcu_reset_sequencer #(
   parameter int unsigned HOLD_CYC = `HOLD_DELAY_CYC,
   parameter int unsigned LV_QUAL = `LV_QUAL_CYC
) (
   input wire logic i_mclk, // 100 MHz system clock.
   input wire logic i_rst_n, // Power-on reset, active low.
   input wire logic i_external_reset_n, // Reset pin level.
   input wire logic i_supply_low, // Supply below threshold.
   input wire logic i_powerdown, // Device in power-down.
   input wire logic i_sleep, // Core is sleeping.
   input wire logic i_wdt_timeout, // Watchdog overflow pulse.
   input wire logic i_wdkey_bad, // Invalid watchdog key written.
   input wire logic i_slow_osc, // Slow internal oscillator.
   input wire logic i_clr_timeout, // Core clears timeout flag.
   input wire logic i_set_powerdown, // Core enters sleep, sets flag.
   input wire logic i_clr_powerdown, // Core clears power-down flag.
   input wire logic [3:0] i_avs_address, // Byte address.
   input wire logic i_avs_read, // Read strobe.
   input wire logic i_avs_write, // Write strobe.
   input wire logic [31:0] i_avs_writedata, // Write data.
   input wire logic [3:0] i_avs_byteenable, // Byte lanes.
   output logic [31:0] o_avs_readdata, // Read data.
   output logic o_avs_waitrequest, // Wait request.
   output logic o_core_rst, // Core held in reset.
   output logic o_pc_sp_clear, // Clear PC and stack pointer.
   output logic o_wdt_clear, // Clear watchdog counter.
   output logic o_timer_off, // Stop timer, clear prescaler.
   output logic o_irq_disable, // Disable all interrupts.
   output logic o_sp_top, // Stack pointer to top.
   output logic o_io_inputs, // Set port data and direction high.
   output logic o_shared_port_bit_is_reset, // Shared pin is reset input.
   output logic o_timeout_flag, // Timeout flag.
   output logic o_powerdown_flag, // Power-down flag.
   output logic [2:0] o_cause, // Last reset cause.
   output logic o_irq // Interrupt.
);
   localparam logic [31:0] HOLD_W = 32'(HOLD_CYC);
   localparam logic [31:0] LVQ_W = 32'(LV_QUAL);
   localparam logic [31:0] START_W = 32'(`STARTUP_CYC);

   typedef struct packed {
      rstseq_pkg::seq_st_t st;
      rstseq_pkg::cause_t cause;
      rstseq_pkg::rst_out_t out;
      logic [31:0] cnt;
      logic [31:0] lv_cnt;
      logic [4:0] key;
      logic timeout_flag;
      logic powerdown_flag;
      logic [1:0] wd_cnt;
      logic wd_arm;
      logic slow_prev;
      logic pin_prev;
      logic [5:0] irq_st;
      logic [5:0] irq_mask;
      logic irq;
      logic ack;
      logic [31:0] rdata;
      logic pin_is_rst;
      logic waitreq;
   } state_t;

   state_t s_q;
   state_t s_d;
   logic pin_n;
   logic slow;
   logic evt;
   rstseq_pkg::cause_t evt_cause;
   logic [31:0] rd;
   logic [5:0] ev_bits;

   // ==========================================================
   // Synchronisers
   // ==========================================================
   rstseq_sync u_pin_sync (
      .i_mclk(i_mclk),
      .i_rst_n(i_rst_n),
      .i_async(i_external_reset_n),
      .o_level(pin_n)
   );
   rstseq_sync u_slow_sync (
      .i_mclk(i_mclk),
      .i_rst_n(i_rst_n),
      .i_async(i_slow_osc),
      .o_level(slow)
   );

   // ==========================================================
   // Sequencer
   // ==========================================================
   always_comb begin
      s_d = s_q;
      evt = 1'b0;
      evt_cause = rstseq_pkg::CAUSE_PIN;
      ev_bits = 6'h00;
      s_d.slow_prev = slow;
      s_d.pin_prev = pin_n;
      s_d.ack = 1'b0;

      // ==========================================================
      // Low-voltage qualifier
      // ==========================================================
      // The count saturates so a long brown-out gives a single reset.
      // power-down disables
      if (i_supply_low && !i_powerdown) begin
         if (s_q.lv_cnt != LVQ_W) begin
            s_d.lv_cnt = s_q.lv_cnt + 32'h00000001;
         end
      end else begin
         s_d.lv_cnt = 32'h00000000;
      end

      // ==========================================================
      // Watchdog key delay
      // ==========================================================
      // Edges count only once armed, so the delay spans one to two slow periods.
      // delay bad key
      if (s_q.wd_arm) begin
         if (slow && !s_q.slow_prev) begin
            s_d.wd_cnt = s_q.wd_cnt + 2'h1;
         end
      end
      if (i_wdkey_bad && !s_q.wd_arm) begin
         s_d.wd_arm = 1'b1;
         s_d.wd_cnt = 2'h0;
      end

      // ==========================================================
      // Source merge
      // ==========================================================
      // Only the running state takes a new source; one seen mid-sequence is dropped.
      // source merge
      if (s_q.lv_cnt == LVQ_W - 32'h00000001 && i_supply_low && !i_powerdown) begin
         evt = 1'b1;
         evt_cause = rstseq_pkg::CAUSE_LOW_V;
         ev_bits[3] = 1'b1;
      end else if (!pin_n && s_q.key == `KEY_RESET) begin
         evt = 1'b1;
         evt_cause = rstseq_pkg::CAUSE_PIN;
         ev_bits[1] = s_q.pin_prev;
      end else if (s_q.wd_arm && s_q.wd_cnt == 2'(`WDKEY_MIN_SLOW)) begin
         evt = 1'b1;
         evt_cause = rstseq_pkg::CAUSE_KEY;
         ev_bits[2] = 1'b1;
         s_d.wd_arm = 1'b0;
      end else if (i_wdt_timeout && s_q.st == rstseq_pkg::ST_RUN) begin
         evt = 1'b1;
         evt_cause = i_sleep ? rstseq_pkg::CAUSE_WDT_SLEEP : rstseq_pkg::CAUSE_WDT_RUN;
         ev_bits[i_sleep ? 5 : 4] = 1'b1;
      end

      // ==========================================================
      // Core flag operations
      // ==========================================================
      // Software flag updates; hardware reset events win below.
      if (i_clr_timeout) begin
         s_d.timeout_flag = 1'b0;
      end
      if (i_clr_powerdown) begin
         s_d.powerdown_flag = 1'b0;
      end
      if (i_set_powerdown) begin
         s_d.powerdown_flag = 1'b1;
      end

      // ==========================================================
      // Reset sequence
      // ==========================================================
      unique case (s_q.st)
         rstseq_pkg::ST_RUN: begin
            s_d.out = '0;
            if (evt) begin
               s_d.cause = evt_cause;
               s_d.cnt = 32'h00000000;
               if (evt_cause == rstseq_pkg::CAUSE_WDT_SLEEP) begin
                  s_d.out.pc_sp_clear = 1'b1;
                  s_d.out.core_rst = 1'b1;
                  s_d.timeout_flag = 1'b1;
                  s_d.powerdown_flag = 1'b1;
                  s_d.st = rstseq_pkg::ST_START;
               end else begin
                  s_d.out = '{core_rst: 1'b1, pc_sp_clear: 1'b1, wdt_clear: 1'b1,
                     timer_off: 1'b1, irq_disable: 1'b1, sp_top: 1'b1, io_inputs: 1'b1};
                  if (evt_cause == rstseq_pkg::CAUSE_WDT_RUN) begin
                     s_d.timeout_flag = 1'b1;
                  end
                  s_d.st = rstseq_pkg::ST_ARMED;
               end
            end
         end
         rstseq_pkg::ST_ARMED: begin
            // The delay starts once the pin reads high again.
            // wait pin release
            if (pin_n || s_q.key != `KEY_RESET) begin
               s_d.st = rstseq_pkg::ST_HOLD;
            end
         end
         rstseq_pkg::ST_HOLD: begin
            // A pin still low restarts the delay, so release is clean.
            // hold until expiry
            if (!pin_n && s_q.key == `KEY_RESET) begin
               s_d.cnt = 32'h00000000;
            end else if (s_q.cnt >= HOLD_W - 32'h00000001) begin
               s_d.cnt = 32'h00000000;
               s_d.st = rstseq_pkg::ST_START;
            end else begin
               s_d.cnt = s_q.cnt + 32'h00000001;
            end
         end
         rstseq_pkg::ST_START: begin
            // All reset outputs drop together at the end.
            // sixteen cycles
            if (s_q.cnt >= START_W - 32'h00000001) begin
               s_d.cnt = 32'h00000000;
               s_d.out = '0;
               s_d.st = rstseq_pkg::ST_RUN;
            end else begin
               s_d.cnt = s_q.cnt + 32'h00000001;
            end
         end
      endcase

      // ==========================================================
      // Register bus
      // ==========================================================
      rd = 32'h00000000;
      unique case (i_avs_address)
         `OFS_PIN_SELECT: rd = {27'h0000000, s_q.key};
         `OFS_STATUS: rd = {23'h000000, s_q.st, s_q.cause, s_q.powerdown_flag, s_q.timeout_flag};
         `OFS_IRQ_STATUS: rd = {26'h0000000, s_q.irq_st};
         `OFS_IRQ_MASK: rd = {26'h0000000, s_q.irq_mask};
         default: rd = 32'h00000000;
      endcase
      // Read data is captured when the request is taken.
      if ((i_avs_read || i_avs_write) && !s_q.ack) begin
         s_d.ack = 1'b1;
         s_d.rdata = rd;
      end
      // A write lands only at the edge that sees waitrequest low.
      if (i_avs_write && s_q.ack) begin
         if (i_avs_byteenable[0]) begin
            unique case (i_avs_address)
               `OFS_PIN_SELECT: begin
                  s_d.key = i_avs_writedata[4:0];
                  if (i_avs_writedata[4:0] != `KEY_GPIO &&
                      i_avs_writedata[4:0] != `KEY_RESET &&
                      s_q.st == rstseq_pkg::ST_RUN) begin
                     s_d.wd_arm = s_d.wd_arm;
                     s_d.out = '{core_rst: 1'b1, pc_sp_clear: 1'b1, wdt_clear: 1'b1,
                        timer_off: 1'b1, irq_disable: 1'b1, sp_top: 1'b1, io_inputs: 1'b1};
                     s_d.cause = rstseq_pkg::CAUSE_KEY;
                     s_d.cnt = 32'h00000000;
                     s_d.st = rstseq_pkg::ST_HOLD;
                     ev_bits[2] = 1'b1;
                  end
               end
               `OFS_IRQ_STATUS: s_d.irq_st = s_q.irq_st & ~i_avs_writedata[5:0];
               `OFS_IRQ_MASK: s_d.irq_mask = i_avs_writedata[5:0];
               default: s_d.irq_mask = s_d.irq_mask;
            endcase
         end
      end
      // ==========================================================
      // Interrupts
      // ==========================================================
      // Events set after clears so a set wins.
      s_d.irq_st = s_d.irq_st | ev_bits;
      s_d.irq = |(s_d.irq_st & s_d.irq_mask);

      // ==========================================================
      // Registered pin mode and waitrequest
      // ==========================================================
      // Both outputs leave a flop so the pins never see decode glitches.
      s_d.pin_is_rst = (s_d.key == `KEY_RESET);
      s_d.waitreq = !s_d.ack;
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         s_q <= '{st: rstseq_pkg::ST_HOLD, cause: rstseq_pkg::CAUSE_POR,
            out: '{core_rst: 1'b1, pc_sp_clear: 1'b1, wdt_clear: 1'b1, timer_off: 1'b1,
               irq_disable: 1'b1, sp_top: 1'b1, io_inputs: 1'b1},
            cnt: 32'h00000000, lv_cnt: 32'h00000000, key: 5'h00,
            timeout_flag: 1'b0, powerdown_flag: 1'b0, wd_cnt: 2'h0, wd_arm: 1'b0,
            slow_prev: 1'b1, pin_prev: 1'b1, irq_st: 6'h01, irq_mask: 6'h00, irq: 1'b0,
            ack: 1'b0, rdata: 32'h00000000, pin_is_rst: 1'b0, waitreq: 1'b1};
      end else begin
         s_q <= s_d;
      end
   end

   // ==========================================================
   // Outputs
   // ==========================================================
   assign o_core_rst = s_q.out.core_rst;
   assign o_pc_sp_clear = s_q.out.pc_sp_clear;
   assign o_wdt_clear = s_q.out.wdt_clear;
   assign o_timer_off = s_q.out.timer_off;
   assign o_irq_disable = s_q.out.irq_disable;
   assign o_sp_top = s_q.out.sp_top;
   assign o_io_inputs = s_q.out.io_inputs;
   assign o_shared_port_bit_is_reset = s_q.pin_is_rst;
   assign o_timeout_flag = s_q.timeout_flag;
   assign o_powerdown_flag = s_q.powerdown_flag;
   assign o_cause = s_q.cause;
   assign o_irq = s_q.irq;
   assign o_avs_readdata = s_q.rdata;
   assign o_avs_waitrequest = s_q.waitreq;
endmodule

/* rstseq_regs.svh */
`ifndef RSTSEQ_REGS_SVH
`define RSTSEQ_REGS_SVH
// Register byte addresses.
`define OFS_PIN_SELECT 4'h0
`define OFS_STATUS 4'h4
`define OFS_IRQ_STATUS 4'h8
`define OFS_IRQ_MASK 4'hC
// Pin-select key values.
`define KEY_GPIO 5'h00
`define KEY_RESET 5'h15
`define PIN_SELECT_RESET 8'h00
// Timing.
`define CLK_MHZ 100
`define HOLD_DELAY_MS 50
`define HOLD_DELAY_CYC (`HOLD_DELAY_MS * 1000 * `CLK_MHZ)
`define STARTUP_CYC 16
`define WDKEY_MIN_SLOW 2
`define LV_QUAL_CYC 100
`endif

/* rstseq_pkg.sv */
package rstseq_pkg;
   typedef enum logic [3:0] {
      ST_RUN = 4'h1,
      ST_HOLD = 4'h2,
      ST_START = 4'h4,
      ST_ARMED = 4'h8
   } seq_st_t;
   typedef enum logic [2:0] {
      CAUSE_POR = 3'h0,
      CAUSE_PIN = 3'h1,
      CAUSE_KEY = 3'h2,
      CAUSE_LOW_V = 3'h3,
      CAUSE_WDT_RUN = 3'h4,
      CAUSE_WDT_SLEEP = 3'h5
   } cause_t;
   typedef struct packed {
      logic core_rst;
      logic pc_sp_clear;
      logic wdt_clear;
      logic timer_off;
      logic irq_disable;
      logic sp_top;
      logic io_inputs;
   } rst_out_t;
endpackage

/* rstseq_sync.sv */
`timescale 1ns/1ps
// Three-stage input synchroniser; output changes when stages two and three agree.
module rstseq_sync (
   input wire logic i_mclk, // System clock.
   input wire logic i_rst_n, // Synchronous reset.
   input wire logic i_async, // Asynchronous input.
   output logic o_level // Filtered level.
);
   typedef struct packed {
      logic [2:0] sh;
      logic lvl;
   } st_t;
   st_t s_q;
   st_t s_d;
   always_comb begin
      s_d = s_q;
      s_d.sh = {s_q.sh[1:0], i_async};
      if (s_q.sh[1] == s_q.sh[2]) begin
         s_d.lvl = s_q.sh[2];
      end
   end
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         s_q <= '{sh: 3'h7, lvl: 1'b1};
      end else begin
         s_q <= s_d;
      end
   end
   assign o_level = s_q.lvl;
endmodule

/* reset_pin_model.sv */
`timescale 1ns/1ps
// ============================================================
// Reset pin with pull-up and the slow oscillator.
module reset_pin_model #(
   parameter int unsigned SLOW_HALF = 8
) (
   input wire logic i_mclk, // System clock.
   input wire logic i_pull_low, // Hold the pin low.
   output logic o_external_reset_n, // Pin level.
   output logic o_slow_osc // Slow oscillator.
);
   int unsigned div_q = 0;
   logic slow_q = 1'h0;
   always @(posedge i_mclk) begin
      div_q <= (div_q == SLOW_HALF - 1) ? 0 : div_q + 1;
      if (div_q == SLOW_HALF - 1) begin
         slow_q <= ~slow_q;
      end
   end
   assign o_slow_osc = slow_q;
   // The pull-up returns a released pin high.
   assign o_external_reset_n = ~i_pull_low;
endmodule

/* mcu_reset_sequencer_properties.sv */
`timescale 1ns/1ps
// ============================================================
// Port checker.
module rstseq_checker #(
   parameter int unsigned HOLD_CYC = 20,
   parameter int unsigned LV_QUAL = 5
) (
   input wire logic i_mclk, // Clock.
   input wire logic i_rst_n, // Reset.
   input wire logic i_supply_low, // Low.
   input wire logic i_powerdown, // Down.
   input wire logic i_sleep, // Sleep.
   input wire logic i_wdt_timeout, // Overflow.
   input wire logic [3:0] i_avs_address, // Address.
   input wire logic i_avs_write, // Write.
   input wire logic [31:0] i_avs_writedata, // Data.
   input wire logic [3:0] i_avs_byteenable, // Lanes.
   input wire logic o_avs_waitrequest, // Wait.
   input wire logic o_core_rst, // Core.
   input wire logic o_pc_sp_clear, // PC.
   input wire logic o_wdt_clear, // Watchdog.
   input wire logic o_timer_off, // Timer.
   input wire logic o_irq_disable, // Irq.
   input wire logic o_sp_top, // Stack.
   input wire logic o_io_inputs, // Ports.
   input wire logic o_timeout_flag, // Timeout.
   input wire logic o_powerdown_flag, // Down flag.
   input wire logic [2:0] o_cause // Cause.
);
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (!i_rst_n);
   int unsigned lv_cnt_q;
   int unsigned hold_cnt_q;
   logic key_wr;
   assign key_wr = i_avs_write && !o_avs_waitrequest && i_avs_address == 4'h0
      && i_avs_byteenable[0] && !o_core_rst;
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         lv_cnt_q <= 0;
         hold_cnt_q <= 0;
      end else begin
         lv_cnt_q <= i_supply_low ? lv_cnt_q + 1 : 0;
         hold_cnt_q <= o_core_rst ? hold_cnt_q + 1 : 0;
      end
   end
   a_por_state:
   assert property ($rose(i_rst_n) |-> o_core_rst && o_io_inputs && o_irq_disable
      && o_timer_off && o_sp_top && o_wdt_clear && o_cause == 3'h0) else $error("por state");
   a_wdt_run:
   assert property (i_wdt_timeout && !i_sleep && !o_core_rst |-> ##[1:2]
      (o_core_rst && o_timeout_flag && o_cause == 3'h4)) else $error("wdt run");
   a_wdt_sleep:
   assert property (i_wdt_timeout && i_sleep && !o_core_rst |-> ##[1:2] (o_pc_sp_clear
      && o_timeout_flag && o_powerdown_flag && !o_io_inputs && !o_timer_off))
      else $error("wdt sleep");
   a_lv_qualify:
   assert property ($rose(o_core_rst) && o_cause == 3'h3 |-> lv_cnt_q >= LV_QUAL)
      else $error("lv early");
   a_lv_powerdown:
   assert property (i_powerdown && !o_core_rst |=> !o_core_rst || o_cause != 3'h3)
      else $error("lv in powerdown");
   a_key_reset:
   assert property (key_wr && i_avs_writedata[4:0] != 5'h00 && i_avs_writedata[4:0] != 5'h15
      |-> ##[0:2] (o_core_rst && o_pc_sp_clear && o_cause == 3'h2)) else $error("key reset");
   a_sleep_startup:
   assert property ($fell(o_core_rst) && o_cause == 3'h5 |-> hold_cnt_q >= 16)
      else $error("startup short");
   a_pin_hold:
   assert property ($fell(o_core_rst) && (o_cause == 3'h1 || o_cause == 3'h4)
      |-> hold_cnt_q >= HOLD_CYC + 16) else $error("hold short");
endmodule
bind mcu_reset_sequencer rstseq_checker #(.HOLD_CYC(HOLD_CYC), .LV_QUAL(LV_QUAL)) u_chk (.*);

/* mcu_reset_sequencer_tb_top.sv */
`timescale 1ns/1ps
// ============================================================
// Bench: each reset source in turn.
module mcu_reset_sequencer_tb_top;
   localparam int unsigned HOLD = 20;
   logic i_mclk = 1'h0, i_rst_n = 1'h0, i_supply_low = 1'h0, i_powerdown = 1'h0;
   logic i_sleep = 1'h0, i_wdt_timeout = 1'h0, i_wdkey_bad = 1'h0, i_clr_timeout = 1'h0;
   logic i_set_powerdown = 1'h0, i_clr_powerdown = 1'h0, i_avs_read = 1'h0;
   logic i_avs_write = 1'h0;
   logic [3:0] i_avs_address = 4'h0, i_avs_byteenable = 4'hF;
   logic [31:0] i_avs_writedata = 32'h0, o_avs_readdata, q;
   logic pull_low = 1'h0, i_external_reset_n, i_slow_osc, o_avs_waitrequest, o_core_rst;
   logic o_pc_sp_clear, o_wdt_clear, o_timer_off, o_irq_disable, o_sp_top, o_io_inputs;
   logic o_shared_port_bit_is_reset, o_timeout_flag, o_powerdown_flag, o_irq, irq_a;
   logic [2:0] o_cause;
   int failures = 0, samples_checked = 0, cycles = 0, n;
   mcu_reset_sequencer #(.HOLD_CYC(HOLD), .LV_QUAL(5)) u_mcu_reset_sequencer (
      .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_external_reset_n(i_external_reset_n),
      .i_supply_low(i_supply_low), .i_powerdown(i_powerdown), .i_sleep(i_sleep),
      .i_wdt_timeout(i_wdt_timeout), .i_wdkey_bad(i_wdkey_bad), .i_slow_osc(i_slow_osc),
      .i_clr_timeout(i_clr_timeout), .i_set_powerdown(i_set_powerdown),
      .i_clr_powerdown(i_clr_powerdown), .i_avs_address(i_avs_address),
      .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
      .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
      .o_avs_waitrequest(o_avs_waitrequest), .o_core_rst(o_core_rst),
      .o_pc_sp_clear(o_pc_sp_clear), .o_wdt_clear(o_wdt_clear), .o_timer_off(o_timer_off),
      .o_irq_disable(o_irq_disable), .o_sp_top(o_sp_top), .o_io_inputs(o_io_inputs),
      .o_shared_port_bit_is_reset(o_shared_port_bit_is_reset),
      .o_timeout_flag(o_timeout_flag), .o_powerdown_flag(o_powerdown_flag),
      .o_cause(o_cause), .o_irq(o_irq));
   reset_pin_model u_reset_pin_model (.i_mclk(i_mclk), .i_pull_low(pull_low),
      .o_external_reset_n(i_external_reset_n), .o_slow_osc(i_slow_osc));
   always #5 i_mclk = ~i_mclk;
   task automatic summarize();
      if (failures == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   always @(posedge i_mclk) begin
      cycles++;
      if (cycles == 5000) begin
         failures++;
         summarize();
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge i_mclk);
   endtask
   // The request stands until waitrequest is sampled low.
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge i_mclk);
      i_avs_read <= ~w;
      i_avs_write <= w;
      i_avs_address <= a;
      i_avs_writedata <= d;
      do begin
         @(posedge i_mclk);
      end while (o_avs_waitrequest !== 1'h0);
      q = o_avs_readdata;
      i_avs_read <= 1'h0;
      i_avs_write <= 1'h0;
   endtask
   // Counts edges until the core reset is seen released.
   task automatic settle();
      n = 0;
      do begin
         @(posedge i_mclk);
         n++;
      end while (o_core_rst !== 1'h0);
   endtask
   task automatic wdt_pulse();
      @(posedge i_mclk);
      i_wdt_timeout <= 1'h1;
      @(posedge i_mclk);
      i_wdt_timeout <= 1'h0;
   endtask
   task automatic pin_press();
      pull_low <= 1'h1;
      tick(10);
      pull_low <= 1'h0;
   endtask
   // Flag words below read as timeout, power-down, cause.
   initial begin
      tick(16);
      i_rst_n <= 1'h1;
      settle();
      check({o_timeout_flag, o_powerdown_flag, o_cause}, 5'h00, "por flags");
      bus(1'h0, 4'h0, 32'h0);
      check(q, 32'h0, "pin select");
      bus(1'h0, 4'h2, 32'h0);
      check(q, 32'h0, "unmapped");
      bus(1'h1, 4'h8, 32'h3F);
      wdt_pulse();
      settle();
      check(n >= HOLD + 16, 1'h1, "wdt hold");
      check({o_timeout_flag, o_powerdown_flag, o_cause}, 5'h14, "wdt flags");
      bus(1'h0, 4'h8, 32'h0);
      check(q, 32'h10, "irq status");
      bus(1'h1, 4'hC, 32'h0);
      tick(2);
      irq_a = o_irq;
      bus(1'h1, 4'hC, 32'h10);
      tick(2);
      check(irq_a ^ o_irq, 1'h1, "irq mask");
      bus(1'h1, 4'h8, 32'h10);
      tick(2);
      check(o_irq, 1'h0, "irq clear");
      bus(1'h1, 4'h0, 32'h15);
      tick(2);
      check(o_shared_port_bit_is_reset, 1'h1, "pin mode");
      pin_press();
      check({o_core_rst, o_pc_sp_clear, o_wdt_clear, o_timer_off, o_irq_disable, o_sp_top,
         o_io_inputs}, 7'h7F, "pin outputs");
      settle();
      check({o_timeout_flag, o_powerdown_flag, o_cause}, 5'h11, "pin flags");
      @(posedge i_mclk);
      i_clr_timeout <= 1'h1;
      @(posedge i_mclk);
      i_clr_timeout <= 1'h0;
      i_sleep <= 1'h1;
      wdt_pulse();
      settle();
      i_sleep <= 1'h0;
      check(n, 32'h11, "startup edges");
      check({o_timeout_flag, o_powerdown_flag, o_cause}, 5'h1D, "sleep flags");
      i_supply_low <= 1'h1;
      tick(3);
      i_supply_low <= 1'h0;
      tick(10);
      check(o_core_rst, 1'h0, "short low");
      i_powerdown <= 1'h1;
      i_supply_low <= 1'h1;
      tick(8);
      i_supply_low <= 1'h0;
      tick(3);
      i_powerdown <= 1'h0;
      tick(10);
      check(o_core_rst, 1'h0, "low in powerdown");
      i_supply_low <= 1'h1;
      tick(8);
      i_supply_low <= 1'h0;
      settle();
      check({o_timeout_flag, o_powerdown_flag, o_cause}, 5'h1B, "lv flags");
      bus(1'h0, 4'h4, 32'h0);
      check(q, 32'h2F, "status word");
      i_clr_powerdown <= 1'h1;
      @(posedge i_mclk);
      i_clr_powerdown <= 1'h0;
      tick(2);
      check(o_powerdown_flag, 1'h0, "flag clear");
      i_set_powerdown <= 1'h1;
      @(posedge i_mclk);
      i_set_powerdown <= 1'h0;
      tick(2);
      check(o_powerdown_flag, 1'h1, "flag set");
      bus(1'h1, 4'h0, 32'h07);
      settle();
      check(o_cause, 3'h2, "key cause");
      bus(1'h1, 4'h0, 32'h00);
      tick(2);
      check(o_shared_port_bit_is_reset, 1'h0, "io mode");
      pin_press();
      tick(5);
      check(o_core_rst, 1'h0, "pin ignored");
      @(posedge i_slow_osc);
      tick(4);
      i_wdkey_bad <= 1'h1;
      n = 0;
      do begin
         @(posedge i_mclk);
         i_wdkey_bad <= 1'h0;
         n++;
      end while (o_core_rst !== 1'h1 && n < 60);
      check(n >= 32 && n <= 53, 1'h1, "bad key delay");
      settle();
      summarize();
   end
endmodule
